/* File: rtl/scl_defines.vh */
// constants for the serial configuration register loader
`ifndef SCL_DEFINES_VH
`define SCL_DEFINES_VH

// -----------------------------------------------------------------
// word layout
// -----------------------------------------------------------------
`define SCL_WORD_W        32
`define SCL_ADDR_MSB      3
`define SCL_DATA_LSB      4
`define SCL_DATA_MSB      31

// -----------------------------------------------------------------
// register addresses
// -----------------------------------------------------------------
`define SCL_A_SOFT_RESET  4'h0
`define SCL_A_CH0         4'h4
`define SCL_A_CH1         4'h5
`define SCL_A_CH2         4'h6
`define SCL_A_CH3         4'h7
`define SCL_A_FIXED       4'h8
`define SCL_A_PD_RANGE    4'hb
`define SCL_A_REF_FILTER  4'hd
`define SCL_A_PWR_MUX     4'he
`define SCL_A_CAL         4'hf

// -----------------------------------------------------------------
// field positions
// -----------------------------------------------------------------
`define SCL_F_SOFT_RESET  31
`define SCL_F_DLY_MSB     7
`define SCL_F_DLY_LSB     4
`define SCL_F_DIV_MSB     15
`define SCL_F_DIV_LSB     8
`define SCL_F_EN          16
`define SCL_F_MUX_MSB     18
`define SCL_F_MUX_LSB     17
`define SCL_F_PDR         15
`define SCL_F_FREQ_MSB    21
`define SCL_F_FREQ_LSB    14
`define SCL_F_RB_MSB      13
`define SCL_F_RB_LSB      11
`define SCL_F_RA_MSB      10
`define SCL_F_RA_LSB      8
`define SCL_F_CAP_MSB     7
`define SCL_F_CAP_LSB     4

// -----------------------------------------------------------------
// power-on defaults
// -----------------------------------------------------------------
`define SCL_RST_CH        32'h0000_0100
`define SCL_RST_FIXED     32'h0000_0000
`define SCL_RST_PDR       32'h0000_0000
`define SCL_RST_REF       32'h0002_8000
`define SCL_RST_PWR_MUX   32'h0800_0a00
`define SCL_RST_CAL       32'h0802_f800

`endif

/* File: rtl/scl_pin_sync.v */
// two-flop synchroniser with edge detect for the serial pins
`timescale 1ns/1ps

module scl_pin_sync #(
    parameter WIDTH = 3
) (
    // clock and reset
    input  wire             core_clk,
    input  wire             rst_n,
    // raw pins
    input  wire [WIDTH-1:0] pin_in,
    // synchronised view
    output wire [WIDTH-1:0] level,
    output wire [WIDTH-1:0] rise
);

    reg [WIDTH-1:0] meta_reg;
    reg [WIDTH-1:0] sync_reg;
    reg [WIDTH-1:0] prev_reg;

    // first stage feeds only the second; edges seen on stage two
    always @(posedge core_clk) begin
        if (!rst_n) begin
            meta_reg <= {WIDTH{1'b0}};
            sync_reg <= {WIDTH{1'b0}};
            prev_reg <= {WIDTH{1'b0}};
        end else begin
            meta_reg <= pin_in;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    assign level = sync_reg;
    assign rise  = sync_reg & ~prev_reg;

endmodule

/* File: rtl/scl_loader.v */
// serial configuration port and register bank
//
// Notes on behaviour
// - each write is one 32-bit word
// - last four bits select the register
// - preceding 28 bits are register data
// - shift on clock rise while latch low
// - latch rise copies data to addressed register
// - address 15 write loads and starts calibration
// - soft reset restores defaults, self clears
`timescale 1ns/1ps
`include "scl_defines.vh"

module scl_loader #(
    parameter WORD_W = `SCL_WORD_W
) (
    // clock and reset
    input  wire        core_clk,
    input  wire        rst_n,
    // serial programming pins
    input  wire        serial_shift_clock,
    input  wire        serial_data_in,
    input  wire        serial_latch_enable,
    // output channel fields, four channels packed low to high
    output wire [15:0] output_delay_step,
    output wire [31:0] output_divider_value,
    output wire [3:0]  output_enable_bit,
    output wire [7:0]  output_path_select,
    // phase detector and reference settings
    output wire        phase_detector_range_bit,
    output wire [7:0]  reference_freq_mhz,
    output wire [2:0]  loop_filter_resistor_b,
    output wire [2:0]  loop_filter_resistor_a,
    output wire [3:0]  loop_filter_capacitors,
    // whole words of the remaining registers
    output wire [31:0] fixed_pattern_word,
    output wire [31:0] power_mux_word,
    output wire [31:0] calibration_word,
    // one-cycle pulse on each completed address 15 write
    output reg         calibration_start
);

    // -------------------------------------------------------------
    // pin synchronisation
    // -------------------------------------------------------------
    // the host pins are asynchronous, so all three pass the same two
    // flops and keep their relative timing; a pin level held for less
    // than one cycle may be lost
    wire [2:0] pin_level;
    wire [2:0] pin_rise;

    scl_pin_sync #(
        .WIDTH (3)
    ) u_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .pin_in   ({serial_latch_enable, serial_data_in,
                    serial_shift_clock}),
        .level    (pin_level),
        .rise     (pin_rise)
    );

    wire shift_edge = pin_rise[0];
    wire data_bit   = pin_level[1];
    wire latch_low  = ~pin_level[2];
    wire latch_edge = pin_rise[2];

    // -------------------------------------------------------------
    // shift register
    // -------------------------------------------------------------
    reg [WORD_W-1:0] shift_reg;

    // msb enters first and ends at the top after 32 edges
    // extra early bits fall out of the top; only the last 32 count
    always @(posedge core_clk) begin
        if (!rst_n) begin
            shift_reg <= {WORD_W{1'b0}};
        end else if (shift_edge && latch_low) begin
            shift_reg <= {shift_reg[WORD_W-2:0], data_bit};
        end
    end

    // data and address split of the received word; the address nibble
    // is kept in the stored word so the word outputs show it
    wire [3:0]        word_addr = shift_reg[`SCL_ADDR_MSB:0];
    wire [27:0]       word_data =
        shift_reg[`SCL_DATA_MSB:`SCL_DATA_LSB];
    wire [WORD_W-1:0] word_val  = {word_data, word_addr};

    // -------------------------------------------------------------
    // address decode
    // -------------------------------------------------------------
    // one decode shared by the reset and launch paths, so the two can
    // never disagree about which word was latched
    function addr_hit;
        input       load_seen;
        input [3:0] addr;
        input [3:0] target;
        begin
            addr_hit = load_seen && (addr == target);
        end
    endfunction

    // -------------------------------------------------------------
    // register bank
    // -------------------------------------------------------------
    // one whole word per register; the channel words sit in an array
    // so the field slicing below can be a generate loop
    reg  [31:0] ch_reg [0:3];
    reg  [31:0] fixed_reg;
    reg  [31:0] pdr_reg;
    reg  [31:0] ref_reg;
    reg  [31:0] pwr_reg;
    reg  [31:0] cal_reg;

    wire soft_reset = addr_hit(latch_edge, word_addr, `SCL_A_SOFT_RESET)
                    && word_val[`SCL_F_SOFT_RESET];
    wire do_reset   = !rst_n || soft_reset;

    // address 0 holds only the self-clearing reset bit, so nothing
    // else needs storing; other address-0 bits are ignored
    integer i;
    always @(posedge core_clk) begin
        if (do_reset) begin
            for (i = 0; i < 4; i = i + 1) begin
                ch_reg[i] <= `SCL_RST_CH;
            end
            fixed_reg <= `SCL_RST_FIXED;
            pdr_reg   <= `SCL_RST_PDR;
            ref_reg   <= `SCL_RST_REF;
            pwr_reg   <= `SCL_RST_PWR_MUX;
            cal_reg   <= `SCL_RST_CAL;
        end else if (latch_edge) begin
            case (word_addr)
                `SCL_A_CH0: begin
                    ch_reg[0] <= word_val;
                end
                `SCL_A_CH1: begin
                    ch_reg[1] <= word_val;
                end
                `SCL_A_CH2: begin
                    ch_reg[2] <= word_val;
                end
                `SCL_A_CH3: begin
                    ch_reg[3] <= word_val;
                end
                `SCL_A_FIXED: begin
                    fixed_reg <= word_val;
                end
                `SCL_A_PD_RANGE: begin
                    pdr_reg <= word_val;
                end
                `SCL_A_REF_FILTER: begin
                    ref_reg <= word_val;
                end
                `SCL_A_PWR_MUX: begin
                    pwr_reg <= word_val;
                end
                `SCL_A_CAL: begin
                    cal_reg <= word_val;
                end
                default: begin
                    // unused addresses are simply dropped
                end
            endcase
        end
    end

    // calibration launch pulse, aligned with the load of address 15
    // one cycle wide: a new launch needs a new latch edge
    always @(posedge core_clk) begin
        if (!rst_n) begin
            calibration_start <= 1'b0;
        end else begin
            calibration_start <= addr_hit(latch_edge, word_addr,
                                          `SCL_A_CAL);
        end
    end

    // -------------------------------------------------------------
    // field outputs
    // -------------------------------------------------------------
    // plain slices of the stored words: they move only on the load
    // cycle, which keeps every field of a channel consistent
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_ch
            assign output_delay_step[g*4 +: 4] =
                ch_reg[g][`SCL_F_DLY_MSB:`SCL_F_DLY_LSB];
            assign output_divider_value[g*8 +: 8] =
                ch_reg[g][`SCL_F_DIV_MSB:`SCL_F_DIV_LSB];
            assign output_enable_bit[g] = ch_reg[g][`SCL_F_EN];
            assign output_path_select[g*2 +: 2] =
                ch_reg[g][`SCL_F_MUX_MSB:`SCL_F_MUX_LSB];
        end
    endgenerate

    assign phase_detector_range_bit = pdr_reg[`SCL_F_PDR];
    assign reference_freq_mhz =
        ref_reg[`SCL_F_FREQ_MSB:`SCL_F_FREQ_LSB];
    assign loop_filter_resistor_b = ref_reg[`SCL_F_RB_MSB:`SCL_F_RB_LSB];
    assign loop_filter_resistor_a = ref_reg[`SCL_F_RA_MSB:`SCL_F_RA_LSB];
    assign loop_filter_capacitors =
        ref_reg[`SCL_F_CAP_MSB:`SCL_F_CAP_LSB];

    assign fixed_pattern_word = fixed_reg;
    assign power_mux_word     = pwr_reg;
    assign calibration_word   = cal_reg;

endmodule

/* File: testbench/scl_checker.sv */
// port assertions for the serial configuration loader
`timescale 1ns/1ps
module scl_checker (
    // clock, reset, latch pin
    input wire        core_clk,
    input wire        rst_n,
    input wire        serial_latch_enable,
    // register outputs
    input wire [15:0] output_delay_step,
    input wire [31:0] output_divider_value,
    input wire [3:0]  output_enable_bit,
    input wire [7:0]  reference_freq_mhz,
    input wire [3:0]  loop_filter_capacitors,
    input wire [31:0] fixed_pattern_word,
    input wire [31:0] calibration_word,
    input wire        calibration_start
);
    // pin history: a load lands 3 edges after the latch pin rises
    reg  [3:0] le_h;
    wire       ld = le_h[2] & ~le_h[3];
    always @(posedge core_clk) begin
        if (!rst_n)
            le_h <= 4'h0;
        else
            le_h <= {le_h[2:0], serial_latch_enable};
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    property p_ld; calibration_start |-> ld; endproperty
    a_ld: assert property (p_ld)
        else $error("pulse off load slot");
    property p_one; calibration_start |=> !calibration_start; endproperty
    a_one: assert property (p_one)
        else $error("pulse too long");
    property p_addr; calibration_start |-> calibration_word[3:0] == 4'hf;
    endproperty
    a_addr: assert property (p_addr)
        else $error("pulse without address 15");
    property p_ch; !ld |-> $stable({output_delay_step,
        output_divider_value, output_enable_bit}); endproperty
    a_ch: assert property (p_ch)
        else $error("channel field moved");
    property p_ref; !ld |-> $stable({reference_freq_mhz,
        loop_filter_capacitors}); endproperty
    a_ref: assert property (p_ref)
        else $error("reference field moved");
    property p_word; !ld |-> $stable({fixed_pattern_word,
        calibration_word}); endproperty
    a_word: assert property (p_word)
        else $error("word moved");
    property p_por; $rose(rst_n) |-> output_enable_bit == 4'h0 &&
        output_divider_value == 32'h0101_0101; endproperty
    a_por: assert property (p_por)
        else $error("bad defaults");
    property p_fix; fixed_pattern_word[3:0] == 4'h0 ||
        fixed_pattern_word[3:0] == 4'h8; endproperty
    a_fix: assert property (p_fix)
        else $error("fixed word address wrong");
    c_cal: cover property (calibration_start);
    c_ld: cover property (ld && $changed(output_enable_bit));
    c_por: cover property ($rose(rst_n));
endmodule

/* File: testbench/scl_host.sv */
// host model driving the three serial programming pins
`timescale 1ns/1ps
module scl_host (
    // clock
    input wire core_clk,
    // serial pins
    output reg serial_shift_clock,
    output reg serial_data_in,
    output reg serial_latch_enable
);
    // lines start parked low
    initial begin
        serial_shift_clock = 1'b0;
        serial_data_in = 1'b0;
        serial_latch_enable = 1'b0;
    end
    // one word msb first on an 800 ns clock, then the latch pulse
    task send(input [31:0] w);
        integer i;
        begin
            @(posedge core_clk);
            for (i = 31; i >= 0; i = i - 1) begin
                serial_data_in <= w[i];
                repeat (4) @(posedge core_clk);
                serial_shift_clock <= 1'b1;
                repeat (4) @(posedge core_clk);
                serial_shift_clock <= 1'b0;
            end
            @(posedge core_clk) serial_latch_enable <= 1'b1;
            repeat (8) @(posedge core_clk);
            serial_latch_enable <= 1'b0;
            serial_data_in <= 1'b0;
        end
    endtask
endmodule

/* File: testbench/serial_config_register_loader_tb.sv */
// self-checking bench for the serial configuration loader
`timescale 1ns/1ps
`include "scl_defines.vh"
module serial_config_register_loader_tb;
    reg          core_clk = 1'b0;
    reg          rst_n = 1'b0;
    wire         serial_shift_clock, serial_data_in, serial_latch_enable;
    wire [15:0]  output_delay_step;
    wire [31:0]  output_divider_value, fixed_pattern_word;
    wire [31:0]  power_mux_word, calibration_word;
    wire [3:0]   output_enable_bit, loop_filter_capacitors;
    wire [7:0]   output_path_select, reference_freq_mhz;
    wire [2:0]   loop_filter_resistor_b, loop_filter_resistor_a;
    wire         phase_detector_range_bit, calibration_start;
    integer      err_total = 0;
    integer      n_checks = 0;
    reg  [31:0]  m [0:15];
    reg  [175:0] q [$];
    wire [175:0] obs = {calibration_start, output_delay_step,
        output_divider_value, output_enable_bit, output_path_select,
        phase_detector_range_bit, reference_freq_mhz,
        loop_filter_resistor_b, loop_filter_resistor_a,
        loop_filter_capacitors, fixed_pattern_word, power_mux_word,
        calibration_word};
    initial forever #50 core_clk = ~core_clk;
    scl_host host_u (.core_clk, .serial_shift_clock, .serial_data_in,
        .serial_latch_enable);
    scl_loader dut_u (.core_clk, .rst_n, .serial_shift_clock,
        .serial_data_in, .serial_latch_enable, .output_delay_step,
        .output_divider_value, .output_enable_bit, .output_path_select,
        .phase_detector_range_bit, .reference_freq_mhz,
        .loop_filter_resistor_b, .loop_filter_resistor_a,
        .loop_filter_capacitors, .fixed_pattern_word, .power_mux_word,
        .calibration_word, .calibration_start);
    // expected port image from the modelled register words
    function [175:0] expv(input c);
        expv = {c, m[7][7:4], m[6][7:4], m[5][7:4], m[4][7:4],
            m[7][15:8], m[6][15:8], m[5][15:8], m[4][15:8],
            m[7][16], m[6][16], m[5][16], m[4][16],
            m[7][18:17], m[6][18:17], m[5][18:17], m[4][18:17],
            m[11][15], m[13][21:14], m[13][13:11], m[13][10:8],
            m[13][7:4], m[8], m[14], m[15]};
    endfunction
    task defaults;
        integer i;
        begin
            for (i = 0; i < 16; i = i + 1)
                m[i] = (i > 3 && i < 8) ? `SCL_RST_CH : 32'h0;
            m[13] = `SCL_RST_REF;
            m[14] = `SCL_RST_PWR_MUX;
            m[15] = `SCL_RST_CAL;
        end
    endtask
    // note the expected image, then send the word
    task wr(input [31:0] w);
        begin
            if (w[3:0] == 4'h0 && w[31])
                defaults;
            else if (w[3:0] != 4'h0)
                m[w[3:0]] = w;
            q.push_back(expv(w[3:0] == 4'hf));
            host_u.send(w);
        end
    endtask
    task chk(input [175:0] e);
        begin
            n_checks = n_checks + 1;
            if (obs !== e) begin
                err_total = err_total + 1;
                $display("mismatch at %0t: got %h want %h", $time, obs, e);
            end
        end
    endtask
    // outputs and the launch pulse show 3 edges after the latch rise
    always @(posedge serial_latch_enable) begin
        repeat (3) @(posedge core_clk);
        #1 chk(q.pop_front());
    end
    task tally_and_finish;
        begin
            $display("checks %0d mismatches %0d", n_checks, err_total);
            if (err_total == 0 && n_checks > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    initial begin
        #3_000_000;
        err_total = err_total + 1;
        tally_and_finish;
    end
    initial begin
        integer i;
        reg [31:0] w;
        defaults;
        w = $urandom(51);
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        #1 chk(expv(1'b0));
        wr(32'h8000_0000);
        // two ascending passes, address 15 last each time
        for (i = 0; i < 32; i = i + 1) begin
            w = $urandom;
            wr({w[31:4], i[3:0]});
        end
        wr(32'hffff_fff0);
        wr(32'h1234_567f);
        repeat (20) @(posedge core_clk);
        tally_and_finish;
    end
endmodule
bind scl_loader scl_checker chk_u (.core_clk, .rst_n, .serial_latch_enable,
    .output_delay_step, .output_divider_value, .output_enable_bit,
    .reference_freq_mhz, .loop_filter_capacitors, .fixed_pattern_word,
    .calibration_word, .calibration_start);
